//--- sbt_map.svh
// register offsets, field positions and timing figures of the self-test controller
`ifndef SBT_MAP_SVH
`define SBT_MAP_SVH

// ----------------------------------------------------------------------
// own register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define SBT_OFF_CTRL 8'h00
`define SBT_OFF_DURATION 8'h04
`define SBT_OFF_SER_BASE 8'h08
`define SBT_OFF_STATUS 8'h0C
`define SBT_OFF_ERR_COUNT 8'h10
`define SBT_OFF_IRQ_STATUS 8'h14
`define SBT_OFF_IRQ_MASK 8'h18

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define SBT_CTRL_START 0
`define SBT_CTRL_STOP 1
`define SBT_CTRL_CLK_SEL 2
`define SBT_IRQ_DONE 0
`define SBT_IRQ_ERROR 1
`define SBT_IRQ_LOCK_LOST 2
`define SBT_IRQ_TIMEOUT 3
`define SBT_IRQ_BUS_ERR 4
`define SBT_IRQ_W 5
`define SBT_ERR_W 16
`define SBT_ERR_MAX 16'hFFFF
`define SBT_RESET_WORD 32'h0000_0000

// ----------------------------------------------------------------------
// serializer local register that is pulsed after the test starts
// ----------------------------------------------------------------------
`define SBT_DEV_TOGGLE_ADDR 32'h0000_0004
`define SBT_DEV_TOGGLE_MASK 32'h0000_0020

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SBT_CLK_MHZ 10
`define SBT_LOCK_TIMEOUT_US 10000
`define SBT_SETTLE_US 10
`define SBT_SETTLE_CYC (`SBT_SETTLE_US * `SBT_CLK_MHZ)

`endif

//--- sbt_pkg.sv
// types shared by the self-test controller files
package sbt_pkg;

    // ------------------------------------------------------------------
    // sequencer states, gray from idle to stop; stop back to idle flips all three bits
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SBT_IDLE = 3'h0,
        SBT_SET = 3'h1,
        SBT_CLEAR = 3'h3,
        SBT_LOCK_WAIT = 3'h2,
        SBT_RUN = 3'h6,
        SBT_STOP = 3'h7
    } sbt_state_e;

    // ------------------------------------------------------------------
    // apb request driven towards the serializer's local register port
    // ------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } sbt_apb_req_s;

endpackage

//--- sbt_sync.sv
// two-flop synchroniser, one pair per bit
`timescale 1ns/100ps
module sbt_sync #(
    parameter int W = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // ------------------------------------------------------------------
    // per-bit pairs
    // ------------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clock) begin
            if (rst) begin
                meta_q[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_q[i] <= async_in[i];
                sync_out[i] <= meta_q[i];
            end
        end
    end
endmodule // sbt_sync

//--- sbt_apb_master.sv
// single-write apb master towards the serializer register port
`timescale 1ns/100ps
module sbt_apb_master (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    output sbt_pkg::sbt_apb_req_s req,
    input wire logic pready,
    input wire logic pslverr,
    output logic done,
    output logic err
);
    import sbt_pkg::*;

    // ------------------------------------------------------------------
    // setup, then access until pready; no cycle count is assumed
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            req <= '0;
            done <= 1'b0;
            err <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!req.psel) begin
                if (start) begin
                    req.psel <= 1'b1;
                    req.penable <= 1'b0;
                    req.pwrite <= 1'b1;
                    req.paddr <= addr;
                    req.pwdata <= wdata;
                end
            end else if (!req.penable) begin
                req.penable <= 1'b1;
            end else if (pready) begin
                req.psel <= 1'b0;
                req.penable <= 1'b0;
                done <= 1'b1;
                err <= pslverr;
            end
        end
    end

    chk_request_held: assert property (@(posedge clock) disable iff (rst)
        req.psel && req.penable && !pready |=> req.psel && req.penable
            && $stable(req.paddr) && $stable(req.pwdata))
        else $error("request changed before pready");

    chk_setup_first: assert property (@(posedge clock) disable iff (rst)
        $rose(req.psel) |-> !req.penable ##1 req.penable)
        else $error("access phase did not follow setup");
endmodule // sbt_apb_master

//--- sbt_ctrl.sv
// self-test controller driving the remote deserializer's test pins
`timescale 1ns/100ps
`include "sbt_map.svh"
module sbt_ctrl #(
    parameter int unsigned LOCK_TIMEOUT_CYC =
        `SBT_LOCK_TIMEOUT_US * `SBT_CLK_MHZ
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic self_test_request_pin,
    output logic self_test_clock_select_pin,
    input wire logic result_pin,
    input wire logic lock_pin,
    output sbt_pkg::sbt_apb_req_s ser_req,
    input wire logic ser_pready,
    input wire logic ser_pslverr
);
    import sbt_pkg::*;

    localparam int SETTLE_C = `SBT_SETTLE_CYC;

    sbt_state_e state_q, state_d;
    logic [31:0] timer_q, timer_d;
    logic [31:0] duration_q;
    logic [31:0] ser_base_q;
    logic clk_sel_q;
    logic [`SBT_IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q;
    logic [`SBT_IRQ_W-1:0] irq_set, irq_clr;
    logic [`SBT_ERR_W-1:0] err_cnt_q, err_cnt_d;
    logic pass_q;
    logic res_prev_q;
    logic req_pin_d;
    logic res_s, lock_s;
    logic mst_done, mst_err;

    // ------------------------------------------------------------------
    // pin inputs, synchronised before use
    // ------------------------------------------------------------------
    sbt_sync #(.W(2)) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in({lock_pin, result_pin}),
        .sync_out({lock_s, res_s})
    );

    // ------------------------------------------------------------------
    // apb slave decode; one wait state so all outputs come from flops
    // ------------------------------------------------------------------
    wire in_page = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'h0);
    wire a_ctrl = in_page && (paddr[7:0] == `SBT_OFF_CTRL);
    wire a_dur = in_page && (paddr[7:0] == `SBT_OFF_DURATION);
    wire a_base = in_page && (paddr[7:0] == `SBT_OFF_SER_BASE);
    wire a_stat = in_page && (paddr[7:0] == `SBT_OFF_STATUS);
    wire a_err = in_page && (paddr[7:0] == `SBT_OFF_ERR_COUNT);
    wire a_irq = in_page && (paddr[7:0] == `SBT_OFF_IRQ_STATUS);
    wire a_mask = in_page && (paddr[7:0] == `SBT_OFF_IRQ_MASK);
    wire a_hit = a_ctrl | a_dur | a_base | a_stat | a_err | a_irq | a_mask;
    wire acc = psel && penable && !pready;
    wire wr_en = psel && penable && pready && pwrite && !pslverr;
    wire busy = (state_q != SBT_IDLE);

    wire [31:0] rd_data =
        a_ctrl ? {29'h0000_0000, clk_sel_q, 2'h0} :
        a_dur ? duration_q :
        a_base ? ser_base_q :
        a_stat ? {25'h000_0000, state_q, pass_q, lock_s, res_s, busy} :
        a_err ? {16'h0000, err_cnt_q} :
        a_irq ? {27'h000_0000, irq_stat_q} :
        a_mask ? {27'h000_0000, irq_mask_q} :
        `SBT_RESET_WORD;

    wire start_wr = wr_en && a_ctrl && pwdata[`SBT_CTRL_START];
    wire stop_wr = wr_en && a_ctrl && pwdata[`SBT_CTRL_STOP];

    always_ff @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `SBT_RESET_WORD;
        end else begin
            pready <= acc;
            pslverr <= acc && !a_hit;
            prdata <= (acc && !pwrite) ? rd_data : `SBT_RESET_WORD;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            duration_q <= `SBT_RESET_WORD;
            ser_base_q <= `SBT_RESET_WORD;
            clk_sel_q <= 1'b0;
            irq_mask_q <= '0;
        end else if (wr_en) begin
            if (a_dur) duration_q <= pwdata;
            if (a_base) ser_base_q <= pwdata;
            if (a_ctrl && !busy) clk_sel_q <= pwdata[`SBT_CTRL_CLK_SEL];
            if (a_mask) irq_mask_q <= pwdata[`SBT_IRQ_W-1:0];
        end
    end

    // clock select is frozen while a test runs; a change mid-test would
    // drop lock at the far end
    always_ff @(posedge clock) begin
        if (rst) begin
            self_test_clock_select_pin <= 1'b0;
        end else begin
            self_test_clock_select_pin <= clk_sel_q;
        end
    end

    // ------------------------------------------------------------------
    // serializer register pulse: set then clear the toggle bit
    // ------------------------------------------------------------------
    wire go_set = (state_q == SBT_IDLE) && start_wr;
    wire go_clear = (state_q == SBT_SET) && mst_done;
    wire mst_start = go_set || go_clear;
    wire [31:0] set_data = ser_base_q | `SBT_DEV_TOGGLE_MASK;
    wire [31:0] clear_data = ser_base_q & ~`SBT_DEV_TOGGLE_MASK;
    wire [31:0] mst_wdata = go_set ? set_data : clear_data;

    sbt_apb_master u_mst (
        .clock(clock),
        .rst(rst),
        .start(mst_start),
        .addr(`SBT_DEV_TOGGLE_ADDR),
        .wdata(mst_wdata),
        .req(ser_req),
        .pready(ser_pready),
        .pslverr(ser_pslverr),
        .done(mst_done),
        .err(mst_err)
    );

    // ------------------------------------------------------------------
    // test sequencer
    // ------------------------------------------------------------------
    wire lock_to = (state_q == SBT_LOCK_WAIT)
        && (timer_q == 32'(LOCK_TIMEOUT_CYC - 1));
    wire run_end = (duration_q != `SBT_RESET_WORD)
        && (timer_q == duration_q - 32'h0000_0001);
    wire settle_end = (timer_q == 32'(SETTLE_C - 1));
    wire res_fall = res_prev_q && !res_s;
    wire in_run = (state_q == SBT_RUN);

    always_comb begin
        state_d = state_q;
        case (state_q)
            SBT_IDLE: begin
                if (go_set) state_d = SBT_SET;
            end
            SBT_SET: begin
                if (mst_done) state_d = SBT_CLEAR;
            end
            SBT_CLEAR: begin
                if (mst_done) state_d = SBT_LOCK_WAIT;
            end
            SBT_LOCK_WAIT: begin
                // checking only counts once lock and a high result are seen
                if (stop_wr || lock_to) begin
                    state_d = SBT_STOP;
                end else if (lock_s && res_s) begin
                    state_d = SBT_RUN;
                end
            end
            SBT_RUN: begin
                if (stop_wr || run_end) state_d = SBT_STOP;
            end
            SBT_STOP: begin
                if (settle_end) state_d = SBT_IDLE;
            end
            default: begin
                state_d = SBT_IDLE;
            end
        endcase
    end

    assign timer_d = (state_d != state_q) ? `SBT_RESET_WORD
        : timer_q + 32'h0000_0001;

    // pin width is the test length; it falls on entry to stop
    assign req_pin_d = (state_d != SBT_IDLE) && (state_d != SBT_STOP);

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= SBT_IDLE;
            timer_q <= `SBT_RESET_WORD;
            self_test_request_pin <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            self_test_request_pin <= req_pin_d;
        end
    end

    // ------------------------------------------------------------------
    // result pin observation
    // ------------------------------------------------------------------
    // half-period low pulses shorter than our clock may be missed; the
    // count is a lower bound, the final level is exact
    assign err_cnt_d = go_set ? '0
        : (in_run && res_fall && err_cnt_q != `SBT_ERR_MAX)
            ? err_cnt_q + 16'h0001 : err_cnt_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            res_prev_q <= 1'b0;
            err_cnt_q <= '0;
            pass_q <= 1'b0;
        end else begin
            res_prev_q <= res_s;
            err_cnt_q <= err_cnt_d;
            if (go_set) begin
                pass_q <= 1'b0;
            end else if (state_q == SBT_STOP && settle_end) begin
                pass_q <= res_s;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupts: sticky, write one to clear, set wins
    // ------------------------------------------------------------------
    assign irq_set[`SBT_IRQ_DONE] = (state_q == SBT_STOP) && settle_end;
    assign irq_set[`SBT_IRQ_ERROR] = in_run && res_fall;
    assign irq_set[`SBT_IRQ_LOCK_LOST] = in_run && !lock_s;
    assign irq_set[`SBT_IRQ_TIMEOUT] = lock_to;
    assign irq_set[`SBT_IRQ_BUS_ERR] = mst_done && mst_err;
    assign irq_clr = (wr_en && a_irq) ? pwdata[`SBT_IRQ_W-1:0] : '0;
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_stat_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq <= |(irq_stat_d & irq_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence seq_toggle_set;
        ser_req.psel && ser_req.penable && ser_pready
            && ((ser_req.pwdata & `SBT_DEV_TOGGLE_MASK) != 32'h0000_0000);
    endsequence

    sequence seq_toggle_clear_issued;
        ser_req.psel && !ser_req.penable
            && ((ser_req.pwdata & `SBT_DEV_TOGGLE_MASK) == 32'h0000_0000);
    endsequence

    chk_toggle_order: assert property (@(posedge clock)
        disable iff (rst) seq_toggle_set |-> ##2 seq_toggle_clear_issued)
        else $error("toggle bit not cleared after being set");

    chk_toggle_follows: assert property (@(posedge clock)
        disable iff (rst) $rose(self_test_request_pin) |-> ser_req.psel
            && ser_req.paddr == `SBT_DEV_TOGGLE_ADDR
            && ((ser_req.pwdata & `SBT_DEV_TOGGLE_MASK) != 32'h0000_0000))
        else $error("toggle write did not start with enable");

    chk_pin_during_run: assert property (@(posedge clock)
        disable iff (rst) in_run |-> self_test_request_pin && $stable(
            self_test_clock_select_pin))
        else $error("request pin low or clock changed in run");

    chk_run_after_lock: assert property (@(posedge clock)
        disable iff (rst) $rose(in_run) |-> $past(lock_s) && $past(res_s))
        else $error("run entered without lock and high result");

    chk_error_counted: assert property (@(posedge clock)
        disable iff (rst) in_run && res_fall && err_cnt_q != `SBT_ERR_MAX
            |=> err_cnt_q == $past(err_cnt_q) + 16'h0001)
        else $error("low pulse on result pin not counted");

    chk_stop_drops_pin: assert property (@(posedge clock)
        disable iff (rst) (in_run && stop_wr) |=> state_q == SBT_STOP
            && !self_test_request_pin)
        else $error("stop did not drop the request pin");

    chk_settle_bound: assert property (@(posedge clock)
        disable iff (rst)
        $rose(state_q == SBT_STOP) |-> ##[1:SETTLE_C] state_q == SBT_IDLE)
        else $error("stop did not return to idle in time");

    chk_result_capture: assert property (@(posedge clock)
        disable iff (rst) (state_q == SBT_STOP && state_d == SBT_IDLE)
            |=> pass_q == $past(res_s) && irq_stat_q[`SBT_IRQ_DONE])
        else $error("final result not captured");

    chk_lock_lost_flag: assert property (@(posedge clock)
        disable iff (rst)
        in_run && !lock_s |=> irq_stat_q[`SBT_IRQ_LOCK_LOST])
        else $error("lock loss during run not flagged");

    // irq sees the mask one cycle late, as the register does
    chk_irq_level: assert property (@(posedge clock) disable iff (rst)
        ##1 irq == |(irq_stat_q & $past(irq_mask_q)))
        else $error("interrupt level disagrees with status and mask");
endmodule // sbt_ctrl

//--- sbt_link_model.sv
// behavioural model of the remote link pair behind the controller
`timescale 1ns/100ps
`include "sbt_map.svh"
module sbt_link_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic request_pin,
    input wire logic clock_sel_pin,
    input wire sbt_pkg::sbt_apb_req_s ser_req,
    input wire logic slow,
    input wire logic no_lock,
    input wire logic err_inject,
    output logic result_pin,
    output logic lock_pin,
    output logic ser_pready,
    output logic ser_pslverr,
    output logic [3:0] wr_cnt,
    output logic [31:0] wr_log0,
    output logic [31:0] wr_log1
);
    import sbt_pkg::*;
    logic req_q;
    logic fail_q;
    logic wait_q;
    logic [3:0] delay_q;
    logic [7:0] bc_crc_q;
    wire access = ser_req.psel && ser_req.penable && !ser_pready;
    // test clock choice is accepted as is, both sources behave alike
    wire rise = request_pin && !req_q;
    // a stalled port also answers with an error
    assign ser_pslverr = slow;
    // ------------------------------------------------------------------
    // serializer port and deserializer checker
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            req_q <= 1'b0;
            fail_q <= 1'b0;
            wait_q <= 1'b0;
            delay_q <= 4'h0;
            bc_crc_q <= 8'h00;
            result_pin <= 1'b0;
            lock_pin <= 1'b0;
            ser_pready <= 1'b0;
            wr_cnt <= 4'h0;
            wr_log0 <= 32'h0;
            wr_log1 <= 32'h0;
        end else begin
            req_q <= request_pin;
            ser_pready <= 1'b0;
            wait_q <= 1'b0;
            if (access && slow && !wait_q) begin
                wait_q <= 1'b1;
            end else if (access) begin
                ser_pready <= 1'b1;
                if (ser_req.paddr == `SBT_DEV_TOGGLE_ADDR) begin
                    if (wr_cnt == 4'h0) wr_log0 <= ser_req.pwdata;
                    if (wr_cnt == 4'h1) wr_log1 <= ser_req.pwdata;
                    wr_cnt <= wr_cnt + 4'h1;
                end
            end
            // the crc register is only cleared on entry; nothing ever counts into it
            if (rise) begin
                wr_cnt <= 4'h0;
                fail_q <= 1'b0;
                lock_pin <= 1'b0;
                result_pin <= 1'b0;
                delay_q <= 4'h0;
                bc_crc_q <= 8'h00;
            end else if (request_pin && !lock_pin) begin
                if (wr_cnt == 4'h2 && !no_lock) delay_q <= delay_q + 4'h1;
                if (delay_q == 4'h4) begin
                    lock_pin <= 1'b1;
                    result_pin <= 1'b1;
                end
            end else if (request_pin) begin
                result_pin <= !err_inject;
                if (err_inject) fail_q <= 1'b1;
            end else if (req_q) begin
                result_pin <= lock_pin && !fail_q;
            end
        end
    end
endmodule // sbt_link_model

//--- tb.sv
// self-checking bench for the self-test controller
`timescale 1ns/100ps
`include "sbt_map.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch t=%0t got %0h want %0h", $time, (a), (b)); end end
module tb;
    import sbt_pkg::*;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0] paddr, pwdata, prdata, wr_log0, wr_log1;
    logic req_pin, csel_pin, result_pin, lock_pin, ser_pready, ser_pslverr;
    logic slow, no_lock, err_inject;
    logic [3:0] wr_cnt;
    sbt_apb_req_s ser_req;
    int err_count, checks_done;
    sbt_ctrl #(.LOCK_TIMEOUT_CYC(50)) sbt_ctrl_i (.clock(clock), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .self_test_request_pin(req_pin),
        .self_test_clock_select_pin(csel_pin), .result_pin(result_pin),
        .lock_pin(lock_pin), .ser_req(ser_req), .ser_pready(ser_pready),
        .ser_pslverr(ser_pslverr));
    sbt_link_model sbt_link_model_i (.clock(clock), .rst(rst),
        .request_pin(req_pin), .clock_sel_pin(csel_pin), .ser_req(ser_req),
        .slow(slow), .no_lock(no_lock), .err_inject(err_inject),
        .result_pin(result_pin), .lock_pin(lock_pin),
        .ser_pready(ser_pready), .ser_pslverr(ser_pslverr),
        .wr_cnt(wr_cnt), .wr_log0(wr_log0), .wr_log1(wr_log1));
    // ------------------------------------------------------------------
    // clock, watchdog and verdict
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic conclude();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clock);
        err_count++;
        conclude();
    end
    // ------------------------------------------------------------------
    // apb tasks
    // ------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic er);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // look between edges: the value seen stands at the next rise
        do @(negedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic e;
        apb(1'b1, a, d, v, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] x, input logic xe);
        logic [31:0] v;
        logic e;
        apb(1'b0, a, 32'h0, v, e);
        `CHK(v & m, x)
        `CHK(e, xe)
    endtask
    // polling keeps the wait honest: no cycle count is assumed
    task automatic wait_state(input logic [2:0] st);
        logic [31:0] v;
        logic e;
        int n;
        v = 32'hFFFF_FFFF;
        n = 0;
        while (v[6:4] !== st && n < 2000) begin
            apb(1'b0, `SBT_OFF_STATUS, 32'h0, v, e);
            n++;
        end
        `CHK(v[6:4], st)
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        slow = 1'b0;
        no_lock = 1'b0;
        err_inject = 1'b0;
        err_count = 0;
        checks_done = 0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 7; i++) rdc(8'(i * 4), '1, `SBT_RESET_WORD, 1'b0);
        rdc(8'h1C, '1, 32'h0, 1'b1);
        rdc(8'h02, '1, 32'h0, 1'b1);
        wr(`SBT_OFF_STATUS, 32'hFFFF_FFFF);
        rdc(`SBT_OFF_STATUS, '1, 32'h0, 1'b0);
        wr(`SBT_OFF_IRQ_MASK, 32'h1F);
        rdc(`SBT_OFF_IRQ_MASK, '1, 32'h1F, 1'b0);
        // clean run, fixed length
        wr(`SBT_OFF_DURATION, 32'd40);
        wr(`SBT_OFF_SER_BASE, 32'hA5);
        wr(`SBT_OFF_CTRL, 32'h4);
        repeat (2) @(posedge clock);
        `CHK(csel_pin, 1'b1)
        wr(`SBT_OFF_CTRL, 32'h5);
        repeat (2) @(posedge clock);
        `CHK(req_pin, 1'b1)
        wait_state(SBT_RUN);
        `CHK(wr_cnt, 4'h2)
        `CHK(wr_log0, 32'hA5 | `SBT_DEV_TOGGLE_MASK)
        `CHK(wr_log1, 32'hA5 & ~`SBT_DEV_TOGGLE_MASK)
        wait_state(SBT_IDLE);
        `CHK(req_pin, 1'b0)
        `CHK(irq, 1'b1)
        rdc(`SBT_OFF_STATUS, 32'h79, 32'h08, 1'b0);
        rdc(`SBT_OFF_ERR_COUNT, '1, 32'h0, 1'b0);
        rdc(`SBT_OFF_IRQ_STATUS, '1, 32'h1, 1'b0);
        wr(`SBT_OFF_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge clock);
        `CHK(irq, 1'b0)
        // open-ended run with errors, stalling serializer port
        wr(`SBT_OFF_DURATION, 32'h0);
        slow <= 1'b1;
        wr(`SBT_OFF_SER_BASE, 32'h5A);
        wr(`SBT_OFF_CTRL, 32'h1);
        wait_state(SBT_RUN);
        `CHK(wr_log0, 32'h5A | `SBT_DEV_TOGGLE_MASK)
        `CHK(wr_log1, 32'h5A)
        for (int i = 0; i < 3; i++) begin
            err_inject <= 1'b1;
            repeat (2) @(posedge clock);
            err_inject <= 1'b0;
            repeat (10) @(posedge clock);
        end
        rdc(`SBT_OFF_STATUS, 32'h71, 32'h61, 1'b0);
        wr(`SBT_OFF_CTRL, 32'h2);
        wait_state(SBT_IDLE);
        rdc(`SBT_OFF_STATUS, 32'h79, 32'h0, 1'b0);
        rdc(`SBT_OFF_ERR_COUNT, '1, 32'h3, 1'b0);
        rdc(`SBT_OFF_IRQ_STATUS, '1, 32'h13, 1'b0);
        wr(`SBT_OFF_IRQ_STATUS, 32'h13);
        // lock never gained, interrupt masked first
        wr(`SBT_OFF_IRQ_MASK, 32'h0);
        slow <= 1'b0;
        no_lock <= 1'b1;
        wr(`SBT_OFF_CTRL, 32'h1);
        wait_state(SBT_IDLE);
        rdc(`SBT_OFF_IRQ_STATUS, 32'h9, 32'h9, 1'b0);
        `CHK(irq, 1'b0)
        wr(`SBT_OFF_IRQ_MASK, 32'h8);
        repeat (3) @(posedge clock);
        `CHK(irq, 1'b1)
        wr(`SBT_OFF_IRQ_STATUS, 32'h1F);
        repeat (3) @(posedge clock);
        `CHK(irq, 1'b0)
        conclude();
    end
endmodule // tb
